//--- mrtu_pkg.sv
// Constants for the memory reference trap unit.
// Assumes one 200 MHz clock; one beat is two clock cycles.
package mrtu_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] FVA_OFF = 8'h08;
    localparam logic [7:0] FATTR_OFF = 8'h0c;
    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FLAT_BIT = 2;
    localparam int CTRL_GEN_LSB = 4;
    localparam int CTRL_PID_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // FATTR fields
    localparam int FA_VALID_BIT = 0;
    localparam int FA_R1_LSB = 1;
    localparam int FA_R3_LSB = 3;
    localparam int FA_FMOD_BIT = 5;
    localparam int FA_WAY_BIT = 6;
    localparam int FA_AUTO_BIT = 7;
    localparam int FA_CTL_LSB = 8;
    // ------------------------------------------------------------
    // Addressing modes, address layout, limits
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_VIRT = 2'h0;
    localparam logic [1:0] MODE_SHORT_A = 2'h1;
    localparam logic [1:0] MODE_SHORT_B = 2'h2;
    localparam logic [1:0] MODE_GENREG = 2'h3;
    localparam int AW = 28;
    localparam int SEG_LSB = 16;
    localparam int PG_LSB = 10;
    localparam logic [15:0] VIRT_REG_LAST = 16'h0007;
    localparam logic [15:0] SHORT_REG_LAST = 16'h001f;
    localparam logic [11:0] PRIVATE_SEG = 12'h800;
    localparam int GEN_W = 3;
    localparam int CTL_W = 2;
    localparam int PID_W = 8;
    // Trap priority positions, highest first
    localparam int T_RDREG = 0;
    localparam int T_MISS = 1;
    localparam int T_ACC = 2;
    localparam int T_PMOD = 3;
    localparam int T_WRREG = 4;
    localparam int T_FLAT = 5;
    localparam int T_WRAP = 6;
    localparam int NTRAP = 7;
    localparam int BEAT_CYC = 2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

//--- mrtu_top.sv
// Trap detection and priority for the storage unit, with translation buffer.
// Assumes microcode and pipeline inputs are synchronous to aclk; registers
// are reached over AXI4-Lite.
`timescale 1ns/1ps
module mrtu_top #(
    parameter int TB_SETS = 512
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_valid,
    input wire logic ref_write,
    input wire logic ref_wide,
    input wire logic ref_unaligned,
    input wire logic [1:0] ref_ring,
    input wire logic [mrtu_pkg::AW-1:0] ref_addr,
    input wire logic [31:0] ref_wdata,
    input wire logic [31:0] regfile_rdata,
    input wire logic [mrtu_pkg::AW-1:0] low_address_word,
    input wire logic str_step,
    input wire logic str_dest,
    input wire logic str_dec,
    input wire logic str_fix,
    input wire logic mar_from_src,
    input wire logic mar_from_dst,
    output logic trap_valid,
    output logic [mrtu_pkg::NTRAP-1:0] trap_code,
    output logic ip_hold,
    output logic mem_cancel,
    output logic cache_fill,
    output logic [31:0] cache_fill_data,
    output logic cache_fill_invalid,
    output logic miss_disable,
    output logic cache_force_miss,
    output logic regfile_we,
    output logic [4:0] regfile_waddr,
    output logic [31:0] regfile_wdata,
    output logic cache_addr_load,
    output logic [mrtu_pkg::AW-1:0] cache_addr,
    output logic source_modified_last,
    output logic [31:0] memory_address_register
);
    localparam int IDX_W = $clog2(TB_SETS);
    localparam int TAG_W = mrtu_pkg::AW - mrtu_pkg::PG_LSB - IDX_W;

    if (TB_SETS < 2 || TB_SETS != (1 << IDX_W) || IDX_W > 15) begin : g_bad_sets
        $error("TB_SETS must be a power of two from 2 to 32768");
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, ctrl_q, fva_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_go, fill_go;
    logic [31:0] wmask;

    assign wr_go = !aw_rdy_q && !w_rdy_q && !bvalid_q;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign fill_go = wr_go && awaddr_q == mrtu_pkg::FATTR_OFF;

    // Address and data are taken in either order; response waits for both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= mrtu_pkg::RESP_OK;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_rdy_q && s_axi_awvalid) begin
                aw_rdy_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_rdy_q && s_axi_wvalid) begin
                w_rdy_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q == mrtu_pkg::CTRL_OFF || awaddr_q == mrtu_pkg::FVA_OFF ||
                            awaddr_q == mrtu_pkg::FATTR_OFF || awaddr_q == mrtu_pkg::STAT_OFF) ?
                           mrtu_pkg::RESP_OK : mrtu_pkg::RESP_ERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                aw_rdy_q <= 1'b1;
                w_rdy_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= mrtu_pkg::CTRL_RST;
            fva_q <= 32'h0000_0000;
        end else if (wr_go && awaddr_q == mrtu_pkg::CTRL_OFF) begin
            ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
        end else if (wr_go && awaddr_q == mrtu_pkg::FVA_OFF) begin
            fva_q <= (fva_q & ~wmask) | (wdata_q & wmask);
        end
    end

    logic [1:0] mode;
    logic flat_en;
    logic [mrtu_pkg::GEN_W-1:0] cur_gen;
    logic [mrtu_pkg::PID_W-1:0] cur_pid;
    assign mode = ctrl_q[mrtu_pkg::CTRL_MODE_LSB +: 2];
    assign flat_en = ctrl_q[mrtu_pkg::CTRL_FLAT_BIT];
    assign cur_gen = ctrl_q[mrtu_pkg::CTRL_GEN_LSB +: mrtu_pkg::GEN_W];
    assign cur_pid = ctrl_q[mrtu_pkg::CTRL_PID_LSB +: mrtu_pkg::PID_W];

    // ------------------------------------------------------------
    // Translation buffer storage
    // ------------------------------------------------------------
    logic tb_val [2][TB_SETS];
    logic tb_fm [2][TB_SETS];
    logic [TAG_W-1:0] tb_tag [2][TB_SETS];
    logic [mrtu_pkg::PID_W-1:0] tb_pid [2][TB_SETS];
    logic [1:0] tb_r1 [2][TB_SETS];
    logic [1:0] tb_r3 [2][TB_SETS];
    logic [mrtu_pkg::GEN_W-1:0] tb_gen [2][TB_SETS];
    logic [mrtu_pkg::CTL_W-1:0] tb_ctl [2][TB_SETS];
    logic [IDX_W-1:0] f_idx;
    logic f_way;
    assign f_idx = fva_q[mrtu_pkg::PG_LSB +: IDX_W];
    // Auto fill replaces the way not marked as last filled
    assign f_way = wdata_q[mrtu_pkg::FA_AUTO_BIT] ? tb_ctl[0][f_idx][0] : wdata_q[mrtu_pkg::FA_WAY_BIT];

    // Valid and way bits clear on reset, so a lookup or auto fill never meets an unknown way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int w = 0; w < 2; w++) begin
                for (int s = 0; s < TB_SETS; s++) begin
                    tb_val[w][s] <= 1'b0;
                    tb_ctl[w][s] <= '0;
                end
            end
        end else if (fill_go) begin
            tb_val[f_way][f_idx] <= wdata_q[mrtu_pkg::FA_VALID_BIT];
            tb_ctl[f_way][f_idx] <= {wdata_q[mrtu_pkg::FA_CTL_LSB + 1], 1'b1};
            tb_ctl[!f_way][f_idx][0] <= 1'b0;
        end
    end

    // Tags and rights are not reset; a cleared valid bit hides them
    always_ff @(posedge aclk) begin
        if (fill_go) begin
            tb_fm[f_way][f_idx] <= wdata_q[mrtu_pkg::FA_FMOD_BIT];
            tb_tag[f_way][f_idx] <= fva_q[mrtu_pkg::AW-1 -: TAG_W];
            tb_pid[f_way][f_idx] <= cur_pid;
            tb_r1[f_way][f_idx] <= wdata_q[mrtu_pkg::FA_R1_LSB +: 2];
            tb_r3[f_way][f_idx] <= wdata_q[mrtu_pkg::FA_R3_LSB +: 2];
            tb_gen[f_way][f_idx] <= cur_gen;
        end
    end

    // ------------------------------------------------------------
    // Trap detection
    // ------------------------------------------------------------
    logic [IDX_W-1:0] idx;
    logic [1:0] hit;
    logic way, tb_hit, in_regs, priv, allowed;
    logic [1:0] rights;
    logic [mrtu_pkg::NTRAP-1:0] cond, pick;
    logic wrap_carry;
    logic [31:0] src_q, dst_q, str_cur;

    assign idx = ref_addr[mrtu_pkg::PG_LSB +: IDX_W];
    assign priv = ref_addr[mrtu_pkg::AW-1:mrtu_pkg::SEG_LSB] >= mrtu_pkg::PRIVATE_SEG;
    always_comb begin
        for (int w = 0; w < 2; w++) begin
            hit[w] = tb_val[w][idx] &&
                     tb_tag[w][idx] == ref_addr[mrtu_pkg::AW-1 -: TAG_W] &&
                     tb_gen[w][idx] == cur_gen &&
                     (!priv || tb_pid[w][idx] == cur_pid);
        end
    end
    assign tb_hit = |hit;
    assign way = hit[1];
    assign rights = ref_ring[1] ? tb_r3[way][idx] : tb_r1[way][idx];
    assign allowed = ref_ring == 2'h0 || (ref_write ? rights[1] : rights[0]);
    assign in_regs = mode == mrtu_pkg::MODE_VIRT ? ref_addr[15:0] <= mrtu_pkg::VIRT_REG_LAST :
                     mode != mrtu_pkg::MODE_GENREG && ref_addr[15:0] <= mrtu_pkg::SHORT_REG_LAST;
    assign str_cur = str_dest ? dst_q : src_q;
    assign wrap_carry = str_dec ? str_cur[15:0] == 16'h0000 : str_cur[15:0] == 16'hffff;

    always_comb begin
        cond = '0;
        cond[mrtu_pkg::T_RDREG] = ref_valid && !ref_write && in_regs;
        cond[mrtu_pkg::T_MISS] = ref_valid && !tb_hit;
        cond[mrtu_pkg::T_ACC] = ref_valid && tb_hit && !allowed;
        cond[mrtu_pkg::T_PMOD] = ref_valid && tb_hit && ref_write && tb_fm[way][idx];
        cond[mrtu_pkg::T_WRREG] = ref_valid && ref_write && in_regs;
        cond[mrtu_pkg::T_FLAT] = ref_valid && !ref_write && ref_wide && flat_en &&
                                 &ref_addr[mrtu_pkg::SEG_LSB-1:0];
        cond[mrtu_pkg::T_WRAP] = str_step && wrap_carry;
        // Lowest set bit is the highest priority; the rest are dropped
        pick = cond & (-cond);
    end

    logic ip_hold_q, trap_q, cancel_q, fill_q, finv_q, mdis_q, fmiss_q;
    logic rwe_q, cal_q, sml_q, inv_v_q;
    logic [mrtu_pkg::NTRAP-1:0] code_q;
    logic [31:0] fdata_q, rwdata_q, mar_q;
    logic [4:0] rwaddr_q;
    logic [mrtu_pkg::AW-1:0] inv_addr_q, caddr_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_q <= 1'b0;
            code_q <= '0;
            ip_hold_q <= 1'b0;
        end else begin
            trap_q <= |pick;
            code_q <= pick;
            // Registered at the detection edge so the pointer is frozen next half beat
            ip_hold_q <= |pick;
        end
    end

    // Read trap: cancel, fill cache from register file, mark invalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cancel_q <= 1'b0;
            fill_q <= 1'b0;
            finv_q <= 1'b0;
            fdata_q <= 32'h0000_0000;
            mdis_q <= 1'b0;
        end else begin
            cancel_q <= pick[mrtu_pkg::T_RDREG] || pick[mrtu_pkg::T_WRREG];
            fill_q <= pick[mrtu_pkg::T_RDREG];
            finv_q <= pick[mrtu_pkg::T_RDREG];
            if (pick[mrtu_pkg::T_RDREG]) begin
                fdata_q <= regfile_rdata;
            end
            // Misses stay off until the retried reference comes in
            if (pick[mrtu_pkg::T_RDREG]) begin
                mdis_q <= 1'b1;
            end else if (ref_valid) begin
                mdis_q <= 1'b0;
            end
        end
    end

    // Entry flagged invalid forces a miss on its next use after the retry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inv_v_q <= 1'b0;
            inv_addr_q <= '0;
            fmiss_q <= 1'b0;
        end else begin
            fmiss_q <= ref_valid && !mdis_q && inv_v_q && ref_addr == inv_addr_q;
            if (pick[mrtu_pkg::T_RDREG]) begin
                inv_v_q <= 1'b1;
                inv_addr_q <= ref_addr;
            end else if (ref_valid && !mdis_q && ref_addr == inv_addr_q) begin
                inv_v_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rwe_q <= 1'b0;
            rwaddr_q <= 5'h00;
            rwdata_q <= 32'h0000_0000;
        end else begin
            rwe_q <= pick[mrtu_pkg::T_WRREG];
            if (pick[mrtu_pkg::T_WRREG]) begin
                rwaddr_q <= ref_addr[4:0];
                rwdata_q <= ref_wdata;
            end
        end
    end

    // Unaligned read: second word address three cycles (one and a half beats) after the first
    logic [mrtu_pkg::BEAT_CYC-1:0] un_sh_q;
    logic [mrtu_pkg::AW-1:0] low_q [mrtu_pkg::BEAT_CYC];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            un_sh_q <= '0;
            cal_q <= 1'b0;
            caddr_q <= '0;
            for (int i = 0; i < mrtu_pkg::BEAT_CYC; i++) begin
                low_q[i] <= '0;
            end
        end else begin
            un_sh_q <= {un_sh_q[mrtu_pkg::BEAT_CYC-2:0], ref_valid && !ref_write && ref_unaligned};
            low_q[0] <= low_address_word;
            for (int i = 1; i < mrtu_pkg::BEAT_CYC; i++) begin
                low_q[i] <= low_q[i-1];
            end
            cal_q <= un_sh_q[mrtu_pkg::BEAT_CYC-1];
            if (un_sh_q[mrtu_pkg::BEAT_CYC-1]) begin
                caddr_q <= low_q[mrtu_pkg::BEAT_CYC-1] + {{(mrtu_pkg::AW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // String address registers
    // ------------------------------------------------------------
    logic [31:0] str_nxt;
    always_comb begin
        str_nxt = str_cur;
        if (str_fix) begin
            // Negative low half means the wrapping step was a decrement
            str_nxt[31:16] = str_cur[15] ? str_cur[31:16] + 16'h0001 : str_cur[31:16] - 16'h0001;
        end else begin
            str_nxt[15:0] = str_dec ? str_cur[15:0] - 16'h0001 : str_cur[15:0] + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_q <= 32'h0000_0000;
            dst_q <= 32'h0000_0000;
            sml_q <= 1'b0;
        end else if (str_step || str_fix) begin
            if (str_dest) begin
                dst_q <= str_nxt;
            end else begin
                src_q <= str_nxt;
            end
            sml_q <= !str_dest;
        end
    end

    // Only path for microcode to see the string registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mar_q <= 32'h0000_0000;
        end else if (mar_from_src) begin
            mar_q <= src_q;
        end else if (mar_from_dst) begin
            mar_q <= dst_q;
        end
    end

    // Read side of the register bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= mrtu_pkg::RESP_OK;
        end else if (ar_rdy_q && s_axi_arvalid) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= mrtu_pkg::RESP_OK;
            case (s_axi_araddr)
                mrtu_pkg::CTRL_OFF: rdata_q <= ctrl_q;
                mrtu_pkg::STAT_OFF: rdata_q <= {22'h000000, mdis_q, sml_q, inv_v_q, code_q};
                mrtu_pkg::FVA_OFF: rdata_q <= fva_q;
                mrtu_pkg::FATTR_OFF: rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= mrtu_pkg::RESP_ERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            ar_rdy_q <= 1'b1;
        end
    end

    assign s_axi_awready = aw_rdy_q;
    assign s_axi_wready = w_rdy_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ar_rdy_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign trap_valid = trap_q;
    assign trap_code = code_q;
    assign ip_hold = ip_hold_q;
    assign mem_cancel = cancel_q;
    assign cache_fill = fill_q;
    assign cache_fill_data = fdata_q;
    assign cache_fill_invalid = finv_q;
    assign miss_disable = mdis_q;
    assign cache_force_miss = fmiss_q;
    assign regfile_we = rwe_q;
    assign regfile_waddr = rwaddr_q;
    assign regfile_wdata = rwdata_q;
    assign cache_addr_load = cal_q;
    assign cache_addr = caddr_q;
    assign source_modified_last = sml_q;
    assign memory_address_register = mar_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    trap_one_hot_a: assert property (trap_valid |-> $onehot(trap_code))
        else $error("more than one trap signalled");
    rdreg_prio_a: assert property (ref_valid && !ref_write && in_regs |=> trap_code[mrtu_pkg::T_RDREG])
        else $error("read register trap lost priority");
    rdreg_effects_a: assert property (trap_code[mrtu_pkg::T_RDREG] && trap_valid |->
        mem_cancel && cache_fill && cache_fill_invalid && miss_disable)
        else $error("read register trap effects missing");
    genreg_none_a: assert property (ref_valid && mode == mrtu_pkg::MODE_GENREG |=>
        !trap_code[mrtu_pkg::T_RDREG] && !trap_code[mrtu_pkg::T_WRREG])
        else $error("register trap in general register mode");
    ring0_free_a: assert property (ref_valid && ref_ring == 2'h0 |=> !trap_code[mrtu_pkg::T_ACC])
        else $error("access violation from ring zero");
    ip_hold_a: assert property (trap_valid |-> ip_hold)
        else $error("pointer not held on trap");
    unal_incr_a: assert property (ref_valid && !ref_write && ref_unaligned |-> ##3
        cache_addr_load && cache_addr == $past(low_address_word, 3) + 1'b1)
        else $error("unaligned second address wrong");
    wrap_trap_a: assert property (str_step && wrap_carry |=> trap_valid)
        else $error("wrap not trapped");
    src_last_a: assert property (str_step && !str_dest |=> source_modified_last)
        else $error("source flag not set");
    wrreg_a: assert property (trap_code[mrtu_pkg::T_WRREG] && trap_valid |-> regfile_we && mem_cancel)
        else $error("register write not redirected");

    miss_c: cover property (trap_valid && trap_code[mrtu_pkg::T_MISS]);
    pmod_c: cover property (trap_valid && trap_code[mrtu_pkg::T_PMOD]);
    rd_retry_c: cover property (trap_code[mrtu_pkg::T_RDREG] ##[1:20] cache_force_miss);
endmodule

//--- mrtu_regfile_model.sv
// Pipeline-side register file model answering read-trap fills.
// Assumes one aclk domain and one-cycle write strobes from the unit.
`timescale 1ns/1ps
module mrtu_regfile_model (
    input wire logic aclk,
    input wire logic regfile_we,
    input wire logic [4:0] regfile_waddr,
    input wire logic [31:0] regfile_wdata,
    input wire logic [4:0] raddr,
    output logic [31:0] regfile_rdata
);
    logic [31:0] mem_q [32];
    // Distinct seed pattern so a fill from the wrong register shows
    initial begin
        for (int i = 0; i < 32; i++) mem_q[i] = 32'h5a00_0000 + i;
    end
    always @(posedge aclk) begin
        if (regfile_we) mem_q[regfile_waddr] <= regfile_wdata;
    end
    assign regfile_rdata = mem_q[raddr];
endmodule

//--- mrtu_top_tb.sv
// Self-checking bench for the trap unit: AXI4-Lite set-up, references, traps.
// Assumes buffer entries are filled before use (tags and rights are not reset).
`timescale 1ns/1ps
module mrtu_top_tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, ref_valid = 0, ref_write = 0, ref_wide = 0, ref_unaligned = 0, str_step = 0;
    logic str_dest = 0, str_dec = 0, str_fix = 0, mar_from_src = 0, mar_from_dst = 0, seen = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, regfile_we, source_modified_last;
    logic trap_valid, ip_hold;
    logic [6:0] exp_code;
    logic [31:0] memory_address_register;
    logic [1:0] ref_ring = 2'h0, s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [4:0] regfile_waddr;
    logic [6:0] trap_code;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [27:0] ref_addr = 28'h0, low_address_word = 28'h0;
    logic [31:0] s_axi_wdata = 32'h0, ref_wdata = 32'h0, s_axi_rdata, regfile_rdata, regfile_wdata;
    logic [6:0] exq [$];
    int miscompares = 0, cmp_count = 0, cyc = 0;
    mrtu_top #(.TB_SETS(8)) mrtu_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ref_valid(ref_valid), .ref_write(ref_write), .ref_wide(ref_wide),
        .ref_unaligned(ref_unaligned), .ref_ring(ref_ring), .ref_addr(ref_addr), .ref_wdata(ref_wdata),
        .regfile_rdata(regfile_rdata), .low_address_word(low_address_word), .str_step(str_step),
        .str_dest(str_dest), .str_dec(str_dec), .str_fix(str_fix), .mar_from_src(mar_from_src),
        .mar_from_dst(mar_from_dst), .trap_valid(trap_valid), .trap_code(trap_code), .ip_hold(ip_hold), .mem_cancel(),
        .cache_fill(), .cache_fill_data(), .cache_fill_invalid(), .miss_disable(), .cache_force_miss(),
        .regfile_we(regfile_we), .regfile_waddr(regfile_waddr), .regfile_wdata(regfile_wdata),
        .cache_addr_load(), .cache_addr(), .source_modified_last(source_modified_last),
        .memory_address_register(memory_address_register));
    mrtu_regfile_model mrtu_regfile_model_i (.aclk(aclk), .regfile_we(regfile_we), .regfile_waddr(regfile_waddr),
        .regfile_wdata(regfile_wdata), .raddr(ref_addr[4:0]), .regfile_rdata(regfile_rdata));
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | (s_axi_awvalid & s_axi_awready);
            w = w | (s_axi_wvalid & s_axi_wready);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    // Expected trap code is queued with the reference; the monitor pairs them
    task automatic rf(input logic w, input logic [1:0] rg, input logic [27:0] a, input logic wd, input logic st,
        input logic [6:0] e);
        @(posedge aclk);
        {ref_valid, ref_write, ref_ring, ref_addr, ref_wide, str_step, str_dec} <= {1'b1, w, rg, a, wd, st, 1'b1};
        ref_wdata <= $urandom;
        ref_unaligned <= 1'($urandom);
        low_address_word <= 28'($urandom);
        exq.push_back(e);
        @(posedge aclk);
        {ref_valid, str_step} <= 2'h0;
    endtask
    task automatic fill(input logic [27:0] a, input logic [31:0] f);
        wr(mrtu_pkg::FVA_OFF, {4'h0, a}, mrtu_pkg::RESP_OK);
        wr(mrtu_pkg::FATTR_OFF, f, mrtu_pkg::RESP_OK);
    endtask
    always @(posedge aclk) begin
        seen <= ref_valid;
        if (seen) begin
            exp_code = exq.pop_front();
            chk({25'h0, trap_code}, {25'h0, exp_code});
            chk({31'h0, trap_valid}, {31'h0, |exp_code});
            chk({31'h0, ip_hold}, {31'h0, |exp_code});
        end
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(89195));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(mrtu_pkg::CTRL_OFF, 32'h0, mrtu_pkg::RESP_OK);
        rd(8'h10, 32'h0, mrtu_pkg::RESP_ERR);
        wr(8'h10, 32'h1, mrtu_pkg::RESP_ERR);
        // Ring 1 read/write, ring 3 read only; page 1 also first-modified
        fill(28'h0, 32'h8f);
        fill(28'h400, 32'haf);
        fill(28'hfc00, 32'h8f);
        $display("test setup done");
        repeat (4) rf(0, 0, {25'h0, 3'($urandom)}, 0, 0, 7'h01);
        rf(0, 0, 28'h8, 0, 0, 7'h00);
        rf(1, 0, 28'h7, 0, 0, 7'h10);
        rf(1, 3, 28'h20, 0, 0, 7'h04);
        rf(1, 1, 28'h20, 0, 0, 7'h00);
        rf(1, 0, 28'h20, 0, 0, 7'h00);
        rf(1, 0, 28'h400, 0, 0, 7'h08);
        rf(1, 3, 28'h400, 0, 0, 7'h04);
        rf(0, 0, 28'h20, 0, 1, 7'h40);
        @(posedge aclk);
        chk({31'h0, source_modified_last}, 32'h1);
        // Low half is now negative, so the fix step raises the high half
        str_fix <= 1'b1;
        @(posedge aclk);
        {str_fix, mar_from_src} <= 2'h1;
        @(posedge aclk);
        mar_from_src <= 1'b0;
        @(posedge aclk);
        chk(memory_address_register, 32'h0001_ffff);
        $display("test virtual done");
        wr(mrtu_pkg::CTRL_OFF, 32'h1, mrtu_pkg::RESP_OK);
        rf(0, 0, 28'h1f, 0, 0, 7'h01);
        rf(0, 0, 28'h20, 0, 0, 7'h00);
        // Bumping the generation retires every filled entry at once
        wr(mrtu_pkg::CTRL_OFF, 32'h10, mrtu_pkg::RESP_OK);
        rf(0, 0, 28'h20, 0, 0, 7'h02);
        rf(0, 0, 28'h3, 0, 0, 7'h01);
        $display("test short and generation done");
        wr(mrtu_pkg::CTRL_OFF, 32'h7, mrtu_pkg::RESP_OK);
        rf(0, 0, 28'hffff, 1, 0, 7'h20);
        rf(0, 0, 28'h5, 0, 0, 7'h00);
        $display("test flat done");
        repeat (3) @(posedge aclk);
        end_sim();
    end
endmodule
